// *** design/sar_adc_pkg.sv ***
// Constants, register map and field layout for the SAR converter sequencer.
// Assumes a 125 MHz instruction clock and word-addressed register access.
package sar_adc_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int RES_W = 12;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam int BUF_DEPTH = 16;
   localparam int MAX_INPUTS = 10;
   // Fastest sample rate, and the clocks per sample that it implies
   localparam int MAX_RATE_SPS = 100_000;
   localparam int MIN_CLKS_PER_SAMPLE = CLK_HZ / MAX_RATE_SPS;
   localparam logic [3:0] CONV_TADS = 4'h0f;
   localparam logic [3:0] ABORT_TADS = 4'h2;
   localparam logic [3:0] SAR_LAST_TAD = 4'hc;

   // Word addresses: 0..15 result buffer, then the six control registers
   localparam logic [ADDR_W-1:0] ADDR_BUF_LAST = 5'h0f;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 5'h11;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_THREE = 5'h12;
   localparam logic [ADDR_W-1:0] ADDR_INPUT_SEL = 5'h13;
   localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_SCAN_SEL = 5'h15;

   // control_reg_one fields
   localparam int C1_ON = 15;
   localparam int C1_FORM_LO = 8;
   localparam int C1_TRIG_LO = 5;
   localparam int C1_IRQ = 4;
   localparam int C1_AUTO = 2;
   localparam int C1_SAMPLE_START_BIT = 1;
   localparam int C1_DONE = 0;
   // control_reg_two fields
   localparam int C2_SCAN = 10;
   localparam int C2_HALF = 7;
   localparam int C2_SPI_LO = 2;
   localparam int C2_SPLIT = 1;
   localparam int C2_ALT = 0;
   // control_reg_three fields
   localparam int C3_AUTO_SAMPLE_TIME_LO = 8;
   localparam int C3_DIV_LO = 0;
   // input_select_reg fields
   localparam int IS_PRI_LO = 0;
   localparam int IS_ALT_LO = 8;

   localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
   localparam logic [2:0] TRIG_EXTERNAL = 3'h1;
   localparam logic [2:0] TRIG_TIMER = 3'h2;
   localparam logic [2:0] TRIG_AUTO = 3'h7;

   localparam logic [1:0] FORM_INT = 2'h0;
   localparam logic [1:0] FORM_SINT = 2'h1;
   localparam logic [1:0] FORM_FRAC = 2'h2;
   localparam logic [1:0] FORM_SFRAC = 2'h3;

   localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

   typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_ABORT} seq_state_t;
endpackage

// *** design/sar_adc_sequencer.sv ***
// Sequencer for a 12-bit successive-approximation converter: register port, sampling
// control, SAR bit search, result buffer, scan and alternate-group input selection.
// Assumes the analog side answers cmp_in within one clock of dac_code changing.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int NUM_INPUTS = MAX_INPUTS
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic timer_trigger,
   input wire logic ext_trigger,
   input wire logic cmp_in,
   output logic sample_en,
   output logic conv_busy,
   output logic [3:0] input_channel,
   output logic [RES_W-1:0] dac_code,
   output logic conv_irq_flag,
   output logic conv_done
);

   seq_state_t state_r, state_nxt;
   logic [DATA_W-1:0] ctrl1_r, ctrl1_nxt;
   logic [DATA_W-1:0] ctrl2_r, ctrl2_nxt;
   logic [DATA_W-1:0] ctrl3_r, ctrl3_nxt;
   logic [DATA_W-1:0] insel_r, insel_nxt;
   logic [DATA_W-1:0] pcfg_r, pcfg_nxt;
   logic [DATA_W-1:0] scan_sel_r, scan_sel_nxt;
   logic [6:0] acc_r, acc_nxt;
   logic [4:0] tad_cnt_r, tad_cnt_nxt;
   logic [3:0] seq_idx_r, seq_idx_nxt;
   logic half_r, half_nxt;
   logic alt_phase_r, alt_phase_nxt;
   logic [4:0] scan_pos_r, scan_pos_nxt;
   logic [3:0] chan_r, chan_nxt;
   logic [RES_W-1:0] dac_r, dac_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [RES_W-1:0] result_mem [BUF_DEPTH];
   logic mem_we;
   logic [3:0] mem_addr;
   logic [RES_W-1:0] mem_wdata;

   logic tad_tick;
   logic [6:0] acc_sum;
   logic [6:0] acc_lim;
   logic [2:0] trig_src;
   logic [3:0] spi;
   logic [4:0] auto_sample_time;
   logic trig_hit;
   logic [3:0] sar_bit;
   logic [3:0] pri_chan;

   // Lowest selected input at or above 'from', wrapping to the lowest selected
   function automatic logic [3:0] next_scan(input logic [DATA_W-1:0] mask,
                                            input logic [4:0] from);
      logic [3:0] hit;
      logic found;
      hit = 4'h0;
      found = 1'b0;
      for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
         if (mask[i] && (5'(i) >= from)) begin
            hit = 4'(i);
            found = 1'b1;
         end
      end
      if (!found) begin
         for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (mask[i]) begin
               hit = 4'(i);
            end
         end
      end
      return hit;
   endfunction

   // 12-bit buffer word to 16-bit bus word
   function automatic logic [DATA_W-1:0] format_word(input logic [RES_W-1:0] d,
                                                     input logic [1:0] form);
      logic [RES_W-1:0] s;
      s = {~d[RES_W-1], d[RES_W-2:0]};
      case (form)
         FORM_INT: format_word = {4'h0, d};
         FORM_SINT: format_word = {{4{s[RES_W-1]}}, s};
         FORM_FRAC: format_word = {d, 4'h0};
         FORM_SFRAC: format_word = {s, 4'h0};
         default: format_word = {4'h0, d};
      endcase
   endfunction

   assign trig_src = ctrl1_r[C1_TRIG_LO +: 3];
   assign spi = ctrl2_r[C2_SPI_LO +: 4];
   assign auto_sample_time = ctrl3_r[C3_AUTO_SAMPLE_TIME_LO +: 5];
   assign sample_en = (state_r == ST_SAMPLE);
   assign conv_busy = (state_r == ST_CONVERT);
   assign input_channel = chan_r;
   assign dac_code = dac_r;
   assign conv_irq_flag = ctrl1_r[C1_IRQ];
   assign conv_done = ctrl1_r[C1_DONE];
   assign reg_rdata = rdata_r;

   always_comb begin
      state_nxt = state_r;
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      ctrl3_nxt = ctrl3_r;
      insel_nxt = insel_r;
      pcfg_nxt = pcfg_r;
      scan_sel_nxt = scan_sel_r;
      tad_cnt_nxt = tad_cnt_r;
      seq_idx_nxt = seq_idx_r;
      half_nxt = half_r;
      alt_phase_nxt = alt_phase_r;
      scan_pos_nxt = scan_pos_r;
      chan_nxt = chan_r;
      dac_nxt = dac_r;
      rdata_nxt = RESET_WORD;
      mem_we = 1'b0;
      mem_addr = 4'h0;
      mem_wdata = dac_r;
      sar_bit = 4'h0;

      // Period (divider+1)/2 cycles, in half cycles; never faster than sys_clk
      acc_sum = acc_r + 7'd2;
      acc_lim = {1'b0, ctrl3_r[C3_DIV_LO +: 6]} + 7'd1;
      tad_tick = (acc_sum >= acc_lim);
      acc_nxt = tad_tick ? acc_sum - acc_lim : acc_sum;
      if (acc_nxt >= acc_lim) begin
         acc_nxt = 7'd0;
      end

      // Register writes; buffer words are not writable
      if (reg_wr) begin
         case (reg_addr)
            ADDR_CTRL_ONE: begin
               ctrl1_nxt[C1_ON] = reg_wdata[C1_ON];
               ctrl1_nxt[C1_FORM_LO +: 2] = reg_wdata[C1_FORM_LO +: 2];
               ctrl1_nxt[C1_TRIG_LO +: 3] = reg_wdata[C1_TRIG_LO +: 3];
               ctrl1_nxt[C1_AUTO] = reg_wdata[C1_AUTO];
               ctrl1_nxt[C1_SAMPLE_START_BIT] = reg_wdata[C1_SAMPLE_START_BIT];
               // Software clears the flag by writing zero
               ctrl1_nxt[C1_IRQ] = ctrl1_r[C1_IRQ] & reg_wdata[C1_IRQ];
               ctrl1_nxt[C1_DONE] = ctrl1_r[C1_DONE] & reg_wdata[C1_DONE];
            end
            ADDR_CTRL_TWO: begin
               ctrl2_nxt[C2_SCAN] = reg_wdata[C2_SCAN];
               ctrl2_nxt[C2_SPI_LO +: 4] = reg_wdata[C2_SPI_LO +: 4];
               ctrl2_nxt[C2_SPLIT] = reg_wdata[C2_SPLIT];
               ctrl2_nxt[C2_ALT] = reg_wdata[C2_ALT];
            end
            ADDR_CTRL_THREE: begin
               ctrl3_nxt[C3_AUTO_SAMPLE_TIME_LO +: 5] = reg_wdata[C3_AUTO_SAMPLE_TIME_LO +: 5];
               ctrl3_nxt[C3_DIV_LO +: 6] = reg_wdata[C3_DIV_LO +: 6];
            end
            ADDR_INPUT_SEL: begin
               insel_nxt[IS_PRI_LO +: 4] = reg_wdata[IS_PRI_LO +: 4];
               insel_nxt[IS_ALT_LO +: 4] = reg_wdata[IS_ALT_LO +: 4];
            end
            ADDR_PORT_CFG: pcfg_nxt = reg_wdata;
            // Only bits of existing inputs take part in the scan
            ADDR_SCAN_SEL: scan_sel_nxt = reg_wdata & DATA_W'((1 << NUM_INPUTS) - 1);
            default: ;
         endcase
      end

      // Formatted buffer read, data in the following cycle
      if (reg_rd) begin
         if (reg_addr <= ADDR_BUF_LAST) begin
            rdata_nxt = format_word(result_mem[reg_addr[3:0]], ctrl1_r[C1_FORM_LO +: 2]);
         end else begin
            case (reg_addr)
               ADDR_CTRL_ONE: rdata_nxt = ctrl1_r;
               ADDR_CTRL_TWO: rdata_nxt = ctrl2_r;
               ADDR_CTRL_THREE: rdata_nxt = ctrl3_r;
               ADDR_INPUT_SEL: rdata_nxt = insel_r;
               ADDR_PORT_CFG: rdata_nxt = pcfg_r;
               ADDR_SCAN_SEL: rdata_nxt = scan_sel_r;
               default: rdata_nxt = RESET_WORD;
            endcase
         end
      end

      pri_chan = ctrl2_r[C2_SCAN] ? next_scan(scan_sel_r, scan_pos_r)
                                  : insel_r[IS_PRI_LO +: 4];

      case (trig_src)
         TRIG_TIMER: trig_hit = timer_trigger;
         TRIG_EXTERNAL: trig_hit = ext_trigger;
         // Auto-start after the programmed periods, at least one
         TRIG_AUTO: trig_hit = tad_tick &&
                               (tad_cnt_r + 5'd1 >= ((auto_sample_time == 5'd0) ? 5'd1 : auto_sample_time));
         default: trig_hit = 1'b0;
      endcase

      case (state_r)
         ST_OFF: begin
            ctrl1_nxt[C1_SAMPLE_START_BIT] = 1'b0;
            if (ctrl1_r[C1_ON]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Acquisition begins with the sample start bit
            if (ctrl1_r[C1_SAMPLE_START_BIT]) begin
               state_nxt = ST_SAMPLE;
               tad_cnt_nxt = 5'd0;
               // Alternate group only on odd conversions of a sequence when enabled
               chan_nxt = (ctrl2_r[C2_ALT] && alt_phase_r) ? insel_r[IS_ALT_LO +: 4]
                                                           : pri_chan;
            end
         end
         ST_SAMPLE: begin
            if (tad_tick) begin
               tad_cnt_nxt = tad_cnt_r + 5'd1;
            end
            // Trigger ends acquisition; software source is the falling sample bit
            if ((trig_src == TRIG_SOFTWARE) ? !ctrl1_r[C1_SAMPLE_START_BIT] : trig_hit) begin
               state_nxt = ST_CONVERT;
               ctrl1_nxt[C1_SAMPLE_START_BIT] = 1'b0;
               tad_cnt_nxt = 5'd0;
               dac_nxt = {1'b1, {(RES_W - 1){1'b0}}};
            end
         end
         ST_CONVERT: begin
            if (tad_tick) begin
               tad_cnt_nxt = tad_cnt_r + 5'd1;
               // One result bit decided per period
               if (tad_cnt_r[3:0] >= 4'h1 && tad_cnt_r[3:0] <= SAR_LAST_TAD) begin
                  sar_bit = SAR_LAST_TAD - tad_cnt_r[3:0];
                  if (!cmp_in) begin
                     dac_nxt[sar_bit] = 1'b0;
                  end
                  if (sar_bit != 4'h0) begin
                     dac_nxt[sar_bit - 4'h1] = 1'b1;
                  end
               end
               if (tad_cnt_r[3:0] == CONV_TADS - 4'h1) begin
                  // Store at the running slot of the active area
                  mem_we = 1'b1;
                  mem_addr = ctrl2_r[C2_SPLIT] ? {half_r, seq_idx_r[2:0]} : seq_idx_r;
                  alt_phase_nxt = ctrl2_r[C2_ALT] ? !alt_phase_r : 1'b0;
                  if (ctrl2_r[C2_SCAN] && !(ctrl2_r[C2_ALT] && alt_phase_r)) begin
                     scan_pos_nxt = {1'b0, chan_r} + 5'd1;
                  end
                  if (seq_idx_r == spi) begin
                     seq_idx_nxt = 4'h0;
                     ctrl1_nxt[C1_DONE] = 1'b1;
                     // Set wins over a coincident software clear
                     ctrl1_nxt[C1_IRQ] = 1'b1;
                     // Swap halves at each interrupt event
                     half_nxt = ctrl2_r[C2_SPLIT] ? !half_r : 1'b0;
                     // Scan restarts from the lowest input
                     scan_pos_nxt = 5'd0;
                     alt_phase_nxt = 1'b0;
                  end else begin
                     seq_idx_nxt = seq_idx_r + 4'h1;
                  end
                  state_nxt = ST_IDLE;
                  if (ctrl1_r[C1_AUTO]) begin
                     ctrl1_nxt[C1_SAMPLE_START_BIT] = 1'b1;
                  end
               end
            end
         end
         ST_ABORT: begin
            ctrl1_nxt[C1_SAMPLE_START_BIT] = 1'b0;
            if (tad_tick) begin
               tad_cnt_nxt = tad_cnt_r + 5'd1;
               // Two periods before sampling may restart
               if (tad_cnt_r[3:0] == ABORT_TADS - 4'h1) begin
                  state_nxt = ctrl1_r[C1_ON] ? ST_IDLE : ST_OFF;
               end
            end
         end
         default: state_nxt = ST_OFF;
      endcase

      // Switching off wins over everything, including a finishing conversion
      if (!ctrl1_r[C1_ON] && state_r != ST_OFF && state_r != ST_ABORT) begin
         mem_we = 1'b0;
         ctrl1_nxt[C1_SAMPLE_START_BIT] = 1'b0;
         ctrl1_nxt[C1_DONE] = (reg_wr && reg_addr == ADDR_CTRL_ONE) ?
                              ctrl1_r[C1_DONE] & reg_wdata[C1_DONE] : ctrl1_r[C1_DONE];
         ctrl1_nxt[C1_IRQ] = (reg_wr && reg_addr == ADDR_CTRL_ONE) ?
                             ctrl1_r[C1_IRQ] & reg_wdata[C1_IRQ] : ctrl1_r[C1_IRQ];
         seq_idx_nxt = seq_idx_r;
         half_nxt = half_r;
         alt_phase_nxt = alt_phase_r;
         scan_pos_nxt = scan_pos_r;
         if (state_r == ST_CONVERT) begin
            state_nxt = ST_ABORT;
            tad_cnt_nxt = 5'd0;
         end else begin
            state_nxt = ST_OFF;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= ST_OFF;
         ctrl1_r <= RESET_WORD;
         ctrl2_r <= RESET_WORD;
         ctrl3_r <= RESET_WORD;
         insel_r <= RESET_WORD;
         pcfg_r <= RESET_WORD;
         scan_sel_r <= RESET_WORD;
         acc_r <= 7'd0;
         tad_cnt_r <= 5'd0;
         seq_idx_r <= 4'h0;
         half_r <= 1'b0;
         alt_phase_r <= 1'b0;
         scan_pos_r <= 5'd0;
         chan_r <= 4'h0;
         dac_r <= '0;
         rdata_r <= RESET_WORD;
      end else begin
         state_r <= state_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= {ctrl2_nxt[DATA_W-1:C2_HALF+1], half_nxt, ctrl2_nxt[C2_HALF-1:0]};
         ctrl3_r <= ctrl3_nxt;
         insel_r <= insel_nxt;
         pcfg_r <= pcfg_nxt;
         scan_sel_r <= scan_sel_nxt;
         acc_r <= acc_nxt;
         tad_cnt_r <= tad_cnt_nxt;
         seq_idx_r <= seq_idx_nxt;
         half_r <= half_nxt;
         alt_phase_r <= alt_phase_nxt;
         scan_pos_r <= scan_pos_nxt;
         chan_r <= chan_nxt;
         dac_r <= dac_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Results survive reset, as the converter contents do
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         result_mem[mem_addr] <= mem_wdata;
      end
   end

endmodule

// *** testbench/sar_adc_monitor.sv ***
// Port checker for the converter sequencer, bound into every instance.
// Assumes control words change only by writes on the register port.
`timescale 1ns/10ps
module sar_adc_monitor
   import sar_adc_pkg::*;
#(
   parameter int NUM_INPUTS = MAX_INPUTS
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic ext_trigger,
   input wire logic sample_en,
   input wire logic conv_busy,
   input wire logic [3:0] input_channel,
   input wire logic conv_irq_flag,
   input wire logic conv_done
);
   logic [DATA_W-1:0] c1_r, c1_nxt;
   logic [5:0] div_r, div_nxt;
   logic [4:0] busy_cnt_r, busy_cnt_nxt;
   always_comb begin
      c1_nxt = c1_r;
      div_nxt = div_r;
      busy_cnt_nxt = conv_busy ? busy_cnt_r + 5'h01 : 5'h00;
      if (reg_wr && reg_addr == ADDR_CTRL_ONE) begin
         c1_nxt = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_CTRL_THREE) begin
         div_nxt = reg_wdata[5:0];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c1_r <= 16'h0000;
         div_r <= 6'h00;
         busy_cnt_r <= 5'h00;
      end else begin
         c1_r <= c1_nxt;
         div_r <= div_nxt;
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence ctrl1_wr;
      reg_wr && reg_addr == ADDR_CTRL_ONE;
   endsequence
   // Sampling under software control, ended by a write that drops the start bit
   sequence sw_end;
      sample_en && c1_r[C1_ON] && c1_r[7:5] == TRIG_SOFTWARE ##0 ctrl1_wr
         ##0 (reg_wdata[C1_ON] && !reg_wdata[C1_SAMPLE_START_BIT]);
   endsequence
   a_conv_entry: assert property ($rose(conv_busy) |-> $past(sample_en))
      else $error("conversion started without sampling");
   a_busy_length: assert property ($fell(conv_busy) && c1_r[C1_ON] && div_r <= 6'h01
      |-> busy_cnt_r == 5'h0f) else $error("conversion length not fifteen periods");
   a_sw_trigger: assert property (sw_end |-> ##[1:2] conv_busy)
      else $error("software end of sampling did not start conversion");
   a_ext_trigger: assert property (sample_en && ext_trigger && c1_r[C1_ON]
      && c1_r[7:5] == TRIG_EXTERNAL |-> ##[1:2] conv_busy) else $error("external trigger lost");
   a_irq_hold: assert property (conv_irq_flag && !(reg_wr && reg_addr == ADDR_CTRL_ONE
      && !reg_wdata[C1_IRQ]) |=> conv_irq_flag) else $error("flag dropped without a clear");
   a_irq_cause: assert property ($rose(conv_irq_flag) |-> $past(conv_busy))
      else $error("flag raised outside a conversion end");
   a_done_irq: assert property ($rose(conv_done) |-> conv_irq_flag)
      else $error("done raised without the flag");
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data without a read");
   a_unmapped_read: assert property (reg_rd && reg_addr > ADDR_SCAN_SEL
      |=> reg_rdata == 16'h0000) else $error("unmapped word not zero");
   // The state follows the enable one clock after the control word does
   a_off_idle: assert property (!c1_r[C1_ON] |=> !sample_en)
      else $error("sampling while off");
   a_abort_quiet: assert property ($fell(conv_busy) && !c1_r[C1_ON]
      |-> !$rose(conv_done) [*4]) else $error("aborted conversion completed");
   a_chan_hold: assert property (conv_busy && $past(conv_busy) |-> $stable(input_channel))
      else $error("channel moved during conversion");
endmodule
bind sar_adc_sequencer sar_adc_monitor #(.NUM_INPUTS(NUM_INPUTS)) mon (
   .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_trigger,
   .sample_en, .conv_busy, .input_channel, .conv_irq_flag, .conv_done
);

// *** testbench/analog_core_model.sv ***
// Behavioural analog side: fixed level per input, one hold stage, one comparator.
// Assumes sample_en marks acquisition and conv_busy marks the bit search.
`timescale 1ns/10ps
module analog_core_model
   import sar_adc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sample_en,
   input wire logic conv_busy,
   input wire logic [3:0] input_channel,
   input wire logic [RES_W-1:0] dac_code,
   output logic cmp_in
);
   logic [RES_W-1:0] held_r = 12'h000;
   logic wander_r = 1'b0;
   always_ff @(posedge sys_clk) begin
      wander_r <= ~wander_r;
      if (sample_en) begin
         held_r <= 12'h05a + {input_channel, 8'h00};
      end
   end
   // Outside a conversion the comparator means nothing, so it must not look steady
   assign cmp_in = conv_busy ? (held_r >= dac_code) : wander_r;
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the converter sequencer over its register port.
// Assumes the analog model beside the design and the bound port checker.
`timescale 1ns/10ps
module tb_top
   import sar_adc_pkg::*;
;
   logic sys_clk, rst_n, reg_wr, reg_rd, timer_trigger, ext_trigger, cmp_in;
   logic sample_en, conv_busy, conv_irq_flag, conv_done;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [3:0] input_channel;
   logic [RES_W-1:0] dac_code;
   int n_fail, comparisons, cycles;
   sar_adc_sequencer #(.NUM_INPUTS(10)) dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .timer_trigger, .ext_trigger, .cmp_in, .sample_en,
      .conv_busy, .input_channel, .dac_code, .conv_irq_flag, .conv_done);
   analog_core_model core (.sys_clk, .sample_en, .conv_busy, .input_channel, .dac_code,
      .cmp_in);
   always #4 sys_clk = ~sys_clk;
   function automatic logic [RES_W-1:0] level(input logic [3:0] ch);
      return 12'h05a + {ch, 8'h00};
   endfunction
   function automatic logic [15:0] fmt(input logic [11:0] r, input logic [1:0] f);
      case (f)
         FORM_INT: return {4'h0, r};
         FORM_SINT: return {{5{~r[11]}}, r[10:0]};
         FORM_FRAC: return {r, 4'h0};
         default: return {~r[11], r[10:0], 4'h0};
      endcase
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   // Bounded wait on busy (sel_irq low) or on the interrupt flag
   task automatic wait_for(input logic sel_irq, input logic lvl);
      logic v;
      v = ~lvl;
      for (int i = 0; i < 400 && v !== lvl; i++) begin
         @(posedge sys_clk);
         #1;
         v = sel_irq ? conv_irq_flag : conv_busy;
      end
      check(16'(v), 16'(lvl));
   endtask
   task automatic start_sample_start_bit(input logic [15:0] c1);
      wr(ADDR_CTRL_ONE, c1);
      wr(ADDR_CTRL_ONE, c1 | 16'h0002);
      @(posedge sys_clk);
      #1;
      check(16'(sample_en), 16'h0001);
   endtask
   task automatic conv(input logic [15:0] c1);
      start_sample_start_bit(c1);
      case (c1[7:5])
         TRIG_SOFTWARE: wr(ADDR_CTRL_ONE, c1);
         TRIG_EXTERNAL: begin
            @(posedge sys_clk);
            ext_trigger <= 1'b1;
            @(posedge sys_clk);
            ext_trigger <= 1'b0;
         end
         default: begin
            @(posedge sys_clk);
            timer_trigger <= 1'b1;
            @(posedge sys_clk);
            timer_trigger <= 1'b0;
         end
      endcase
      wait_for(1'b0, 1'b1);
      wait_for(1'b0, 1'b0);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, timer_trigger, ext_trigger} = 4'h0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int a = 16; a < 23; a++) rd(5'(a), 16'h0000);
      wr(ADDR_SCAN_SEL, 16'hffff);
      rd(ADDR_SCAN_SEL, 16'h03ff);
      wr(ADDR_PORT_CFG, 16'ha5a5);
      rd(ADDR_PORT_CFG, 16'ha5a5);
      // Settings are only reprogrammed with the converter off
      wr(ADDR_CTRL_THREE, 16'h0001);
      wr(ADDR_CTRL_TWO, 16'h0000);
      for (int t = 0; t < 3; t++) begin
         wr(ADDR_INPUT_SEL, 16'h0900 | 16'(t + 3));
         conv(16'h8000 | 16'(t << 5));
         check(16'(conv_irq_flag), 16'h0001);
         check(16'(conv_done), 16'h0001);
         rd(5'h00, 16'(level(4'(t + 3))));
         wr(ADDR_CTRL_ONE, 16'h0000);
      end
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_CTRL_ONE, 16'(f << 8));
         rd(5'h00, fmt(level(4'h5), 2'(f)));
      end
      wr(5'h00, 16'hffff);
      rd(5'h00, fmt(level(4'h5), FORM_SFRAC));
      // Switch off two periods into a conversion of another input
      wr(ADDR_INPUT_SEL, 16'h0007);
      start_sample_start_bit(16'h8000);
      wr(ADDR_CTRL_ONE, 16'h8000);
      wait_for(1'b0, 1'b1);
      wr(ADDR_CTRL_ONE, 16'h0000);
      wait_for(1'b0, 1'b0);
      check(16'(conv_done), 16'h0000);
      rd(5'h00, 16'(level(4'h5)));
      // Auto-start, split halves, groups taken in turn, eight per flag
      wr(ADDR_CTRL_THREE, 16'h0201);
      wr(ADDR_CTRL_TWO, 16'h001f);
      wr(ADDR_INPUT_SEL, 16'h0502);
      rd(ADDR_CTRL_TWO, 16'h001f);
      start_sample_start_bit(16'h80e4);
      for (int h = 0; h < 2; h++) begin
         wait_for(1'b1, 1'b1);
         // Off before the next result lands: the slot counter survives switching off
         if (h == 1) begin
            wr(ADDR_CTRL_ONE, 16'h0000);
         end
         rd(ADDR_CTRL_TWO, h == 0 ? 16'h009f : 16'h001f);
         for (int i = 0; i < 8; i++) begin
            rd(5'(h * 8 + i), 16'(level(i[0] ? 4'h5 : 4'h2)));
         end
         if (h == 0) begin
            wr(ADDR_CTRL_ONE, 16'h80e6);
         end
      end
      // Scan selecting inputs 1, 4, 7 and 9 with three samples per flag, so only 1, 4 and 7 are converted
      wr(ADDR_CTRL_THREE, 16'h0001);
      wr(ADDR_CTRL_TWO, 16'h0408);
      wr(ADDR_SCAN_SEL, 16'h0292);
      wr(ADDR_INPUT_SEL, 16'h0000);
      for (int r = 0; r < 2; r++) begin
         for (int s = 0; s < 3; s++) begin
            conv(16'h8050);
            check(16'(conv_irq_flag), s == 2 ? 16'h0001 : 16'h0000);
         end
         rd(5'h00, 16'(level(4'h1)));
         rd(5'h01, 16'(level(4'h4)));
         rd(5'h02, 16'(level(4'h7)));
         wr(ADDR_CTRL_ONE, 16'h8040);
      end
      end_of_test();
   end
endmodule
